// [src/ep_status_pkg.sv]
// package: register map, field positions, reset values and encodings
package ep_status_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_ENDPOINT_SELECT  = 8'h00;
  localparam logic [7:0] OFS_ENDPOINT_CONTROL = 8'h04;
  localparam logic [7:0] OFS_ENDPOINT_STATUS  = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS       = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK         = 8'h10;

  // ----------------------------------------
  // endpoint status fields
  // ----------------------------------------
  localparam int BIT_CTRL_DIR   = 7;
  localparam int BIT_OUT_B1     = 6;
  localparam int BIT_STALL_REQ  = 5;
  localparam int BIT_IN_READY   = 4;
  localparam int BIT_STALL_SENT = 3;
  localparam int BIT_SETUP_RX   = 2;
  localparam int BIT_OUT_B0     = 1;
  localparam int BIT_IN_DONE    = 0;

  // ----------------------------------------
  // endpoint set and reset values
  // ----------------------------------------
  localparam int          NUM_EP         = 7;
  localparam logic [3:0]  EP_SEL_MAX     = 4'h6;
  localparam logic [3:0]  EP_PP_FIRST    = 4'h4;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [1:0]  KIND_RESET     = 2'h0;
  localparam logic [NUM_EP-1:0] MASK_RESET = 7'h00;

  typedef enum logic [1:0] {
    KIND_CONTROL = 2'b00,
    KIND_ISO     = 2'b01,
    KIND_BULK    = 2'b10,
    KIND_INTR    = 2'b11
  } ep_kind_t;

  typedef enum logic [1:0] {
    HS_ACK   = 2'b00,
    HS_NAK   = 2'b01,
    HS_STALL = 2'b10,
    HS_NONE  = 2'b11
  } handshake_t;

endpackage

// [src/ep_kind_decode.sv]
// module: endpoint kind decode and ping-pong qualification
`timescale 1ns/1ps
module ep_kind_decode
  import ep_status_pkg::*;
(
  // endpoint
  input  wire logic [3:0] ep_i,
  input  wire logic [1:0] kind_field_i,
  // decoded
  output ep_kind_t        kind_o,
  output logic            pingpong_o
);

  always_comb begin
    kind_o     = (ep_i == 4'h0) ? KIND_CONTROL : ep_kind_t'(kind_field_i);
    pingpong_o = (ep_i >= EP_PP_FIRST) && (ep_i <= EP_SEL_MAX);
  end

endmodule

// [src/ep_handshake_sel.sv]
// module: handshake choice for one OUT or IN token
`timescale 1ns/1ps
module ep_handshake_sel
  import ep_status_pkg::*;
(
  // endpoint state
  input  ep_kind_t         kind_i,
  input  wire logic        stall_req_i,
  input  wire logic        bank_full_i,
  // decision
  output handshake_t       hs_o
);

  always_comb begin
    if (stall_req_i && kind_i != KIND_ISO) begin
      hs_o = HS_STALL;
    end else if (kind_i == KIND_ISO) begin
      hs_o = HS_NONE;
    end else if (bank_full_i) begin
      hs_o = HS_NAK;
    end else begin
      hs_o = HS_ACK;
    end
  end

endmodule

// [src/usb_endpoint_status_upper.sv]
// module: upper endpoint status flags, handshake gating and apb register file
//
// Summary of operation
// - The direction flag in bit 7 counts only for a control endpoint.
// - A control endpoint takes data and status stage direction from that flag.
// - Bit 6 is set when a packet lands in bank 1 of ping-pong endpoints 4 to 6.
// - Setting bit 6 raises the endpoint interrupt when it is enabled.
// - While bit 6 is set, OUT packets to bank 1 get NAK except on isochronous or with the stall request set.
// - The stall request in bit 5 makes the next handshake a STALL, except on isochronous.
// - A valid SETUP PID clears the stall request of a control endpoint.
// - The kind field selects control, isochronous, bulk or interrupt; endpoint 0 is control.
// - A requested STALL that was sent sets the stall-sent flag and its interrupt.
// - A valid SETUP sets setup received and clears every other status bit.
// - The status register shows the endpoint picked by the select field.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module usb_endpoint_status_upper
  import ep_status_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // usb engine events
  input  wire logic [3:0]  tok_ep_i,
  input  wire logic        setup_pid_i,
  input  wire logic        out_token_i,
  input  wire logic        out_bank1_i,
  input  wire logic        in_token_i,
  input  wire logic        out_bank1_stored_i,
  input  wire logic        stall_sent_i,
  // handshake answer and stage direction
  output logic             hs_valid_o,
  output logic [1:0]       hs_o,
  output logic             ctrl_dir_in_o,
  // interrupt
  output logic             irq_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [3:0]               sel;
    logic [NUM_EP-1:0][1:0]   kind;
    logic [NUM_EP-1:0][7:0]   status;
    logic [NUM_EP-1:0]        irq_stat;
    logic [NUM_EP-1:0]        irq_mask;
    logic [31:0]              rdata;
    logic                     ready;
    logic                     slverr;
    logic                     hs_valid;
    logic [1:0]               hs;
    logic                     dir_in;
    logic                     irq;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ----------------------------------------
  // decode of the token endpoint
  // ----------------------------------------
  logic       tok_ok;
  logic [2:0] tok_idx;
  ep_kind_t   tok_kind;
  logic       tok_pp;
  handshake_t tok_hs;
  logic       tok_b1_full;
  logic [3:0] tok_ep_safe;

  function automatic logic [2:0] ep_index(input logic [3:0] ep);
    ep_index = (ep <= EP_SEL_MAX) ? ep[2:0] : 3'h0;
  endfunction

  // true for the five mapped register offsets
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == OFS_ENDPOINT_SELECT) || (a == OFS_ENDPOINT_CONTROL) ||
                  (a == OFS_ENDPOINT_STATUS) || (a == OFS_IRQ_STATUS) ||
                  (a == OFS_IRQ_MASK);
  endfunction

  always_comb begin
    tok_ok      = (tok_ep_i <= EP_SEL_MAX);
    tok_idx     = ep_index(tok_ep_i);
    tok_ep_safe = {1'b0, tok_idx};
  end

  ep_kind_decode u_kind (
    .ep_i         (tok_ep_safe),
    .kind_field_i (st_r.kind[tok_idx]),
    .kind_o       (tok_kind),
    .pingpong_o   (tok_pp)
  );

  always_comb begin
    tok_b1_full = out_token_i && tok_pp && out_bank1_i
                  && st_r.status[tok_idx][BIT_OUT_B1];
  end

  ep_handshake_sel u_hs (
    .kind_i      (tok_kind),
    .stall_req_i (st_r.status[tok_idx][BIT_STALL_REQ]),
    .bank_full_i (tok_b1_full),
    .hs_o        (tok_hs)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic       apb_acc;
  logic       apb_wr;
  logic [2:0] sel_idx;
  logic [7:0] wbyte;
  logic       sel_pp;
  ep_kind_t   sel_kind;
  logic       b1_set;

  ep_kind_decode u_sel_kind (
    .ep_i         ({1'b0, sel_idx}),
    .kind_field_i (st_r.kind[sel_idx]),
    .kind_o       (sel_kind),
    .pingpong_o   (sel_pp)
  );

  always_comb begin
    st_nxt  = st_r;
    apb_acc = psel_i && penable_i && !st_r.ready;
    // write lands at the edge where pready is sampled high
    apb_wr  = psel_i && penable_i && st_r.ready && pwrite_i;
    sel_idx = ep_index(st_r.sel);
    wbyte   = pwdata_i[7:0];
    b1_set  = 1'b0;

    st_nxt.ready    = apb_acc;
    st_nxt.slverr   = apb_acc && !addr_mapped(paddr_i);
    st_nxt.hs_valid = 1'b0;

    // firmware writes
    if (apb_wr) begin
      case (paddr_i)
        OFS_ENDPOINT_SELECT: begin
          st_nxt.sel = wbyte[3:0];
        end
        OFS_ENDPOINT_CONTROL: begin
          st_nxt.kind[sel_idx] = wbyte[1:0];
        end
        OFS_ENDPOINT_STATUS: begin
          st_nxt.status[sel_idx] = wbyte;
          if (!sel_pp) begin
            st_nxt.status[sel_idx][BIT_OUT_B1] = 1'b0;
          end
        end
        OFS_IRQ_STATUS: begin
          st_nxt.irq_stat = st_r.irq_stat & ~wbyte[NUM_EP-1:0];
        end
        OFS_IRQ_MASK: begin
          st_nxt.irq_mask = wbyte[NUM_EP-1:0];
        end
        default: begin
          st_nxt.slverr = 1'b0;
        end
      endcase
    end

    // reads; a write answers with zero read data
    if (apb_acc && pwrite_i) begin
      st_nxt.rdata = 32'h00000000;
    end
    if (apb_acc && !pwrite_i) begin
      case (paddr_i)
        OFS_ENDPOINT_SELECT:  st_nxt.rdata = {28'h0000000, st_r.sel};
        OFS_ENDPOINT_CONTROL: st_nxt.rdata = {30'h00000000, st_r.kind[sel_idx]};
        OFS_ENDPOINT_STATUS:  st_nxt.rdata = {24'h000000, st_r.status[sel_idx]};
        OFS_IRQ_STATUS:       st_nxt.rdata = {25'h0000000, st_r.irq_stat};
        OFS_IRQ_MASK:         st_nxt.rdata = {25'h0000000, st_r.irq_mask};
        default: begin
          st_nxt.rdata  = 32'h00000000;
          st_nxt.slverr = 1'b1;
        end
      endcase
    end

    // usb engine events, after firmware so hardware sets win
    if (tok_ok) begin
      if (out_bank1_stored_i && tok_pp) begin
        st_nxt.status[tok_idx][BIT_OUT_B1] = 1'b1;
        b1_set = 1'b1;
      end
      if (stall_sent_i && st_r.status[tok_idx][BIT_STALL_REQ] && tok_kind != KIND_ISO) begin
        st_nxt.status[tok_idx][BIT_STALL_SENT] = 1'b1;
        st_nxt.irq_stat[tok_idx]               = 1'b1;
      end
      if (b1_set) begin
        st_nxt.irq_stat[tok_idx] = 1'b1;
      end
      if (setup_pid_i && tok_kind == KIND_CONTROL) begin
        st_nxt.status[tok_idx] = 8'h00;
        st_nxt.status[tok_idx][BIT_SETUP_RX] = 1'b1;
        st_nxt.irq_stat[tok_idx] = 1'b1;
      end
      if (out_token_i || in_token_i) begin
        st_nxt.hs_valid = 1'b1;
        st_nxt.hs       = (out_token_i && !out_bank1_i && tok_hs == HS_NAK) ? HS_ACK : tok_hs;
      end
    end

    // control stage direction, only meaningful for control kind
    if (tok_kind == KIND_CONTROL) begin
      st_nxt.dir_in = st_r.status[tok_idx][BIT_CTRL_DIR];
    end else begin
      st_nxt.dir_in = 1'b0;
    end

    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r          <= '0;
      st_r.kind     <= {NUM_EP{KIND_RESET}};
      st_r.status   <= {NUM_EP{STATUS_RESET}};
      st_r.irq_mask <= MASK_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_comb begin
    prdata_o      = st_r.rdata;
    pready_o      = st_r.ready;
    pslverr_o     = st_r.slverr;
    hs_valid_o    = st_r.hs_valid;
    hs_o          = st_r.hs;
    ctrl_dir_in_o = st_r.dir_in;
    irq_o         = st_r.irq;
  end

endmodule

// [sim/ep_status_checker.sv]
// checker: port-level timing of the apb answer and the token handshake
`timescale 1ns/1ps
module ep_status_checker
  import ep_status_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  // usb engine
  input  wire logic [3:0]  tok_ep_i,
  input  wire logic        setup_pid_i,
  input  wire logic        out_token_i,
  input  wire logic        out_bank1_i,
  input  wire logic        in_token_i,
  input  wire logic        hs_valid_o,
  input  wire logic [1:0]  hs_o,
  input  wire logic        ctrl_dir_in_o
);
  default clocking dc @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  wire tok = (out_token_i | in_token_i) & (tok_ep_i <= 4'h6);
  sequence s_setup0;
    setup_pid_i && tok_ep_i == 4'h0;
  endsequence
  sequence s_in0;
    in_token_i && tok_ep_i == 4'h0;
  endsequence
  a_hs_after_token: assert property (tok |=> hs_valid_o)
    else $error("no handshake after token");
  a_no_stray_hs: assert property (!tok |=> !hs_valid_o)
    else $error("handshake without token");
  a_nak_bank_only: assert property (out_token_i && !out_bank1_i && tok_ep_i <= 4'h6
    |=> hs_o != HS_NAK) else $error("nak on bank 0");
  a_in_never_nak: assert property (in_token_i && tok_ep_i <= 4'h6 |=> hs_o != HS_NAK)
    else $error("nak on in token");
  a_setup_unstall: assert property (s_setup0 ##[1:4] s_in0 |=> hs_o == HS_ACK)
    else $error("stall kept after setup");
  a_setup_dir_off: assert property (s_setup0 ##1 (tok_ep_i == 4'h0 || tok_ep_i > 4'h6)
    |=> !ctrl_dir_in_o) else $error("direction kept after setup");
  a_ready_timing: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("late apb answer");
  a_error_zero: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0 ##1 !pready_o)
    else $error("error read not zero");
endmodule
bind usb_endpoint_status_upper ep_status_checker chk_i (.*);

// [sim/usb_host_model.sv]
// model: usb host side, one token or bank event per call
`timescale 1ns/1ps
module usb_host_model (
  input  wire logic  sys_clk_i,
  output logic [3:0] tok_ep_o,
  output logic [5:0] ev_o
);
  initial begin
    tok_ep_o = 4'hF;
    ev_o     = 6'h00;
  end
  // ev_o is setup, out, bank1, in, stored, stall sent
  task automatic send(input logic [3:0] ep, input logic [5:0] f);
    @(posedge sys_clk_i);
    tok_ep_o <= ep;
    ev_o     <= f;
    @(posedge sys_clk_i);
    tok_ep_o <= ~ep;
    ev_o     <= 6'h00;
  endtask
endmodule

// [sim/tb_usb_endpoint_status_upper.sv]
// testbench: endpoint status flags over apb with host token traffic
`timescale 1ns/1ps
module tb_usb_endpoint_status_upper
  import ep_status_pkg::*;
;
  logic sys_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, hs_valid_o, ctrl_dir_in_o, irq_o;
  logic [1:0] hs_o;
  logic [3:0] tok_ep;
  logic [5:0] ev;
  logic [32:0] rq[$];
  logic [1:0] hq[$];
  int err_count = 0, cmp_count = 0, ep;
  always #10 sys_clk_i = ~sys_clk_i;
  usb_host_model host (.sys_clk_i(sys_clk_i), .tok_ep_o(tok_ep), .ev_o(ev));
  usb_endpoint_status_upper uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .tok_ep_i(tok_ep), .setup_pid_i(ev[5]), .out_token_i(ev[4]), .out_bank1_i(ev[3]),
    .in_token_i(ev[2]), .out_bank1_stored_i(ev[1]), .stall_sent_i(ev[0]),
    .hs_valid_o(hs_valid_o), .hs_o(hs_o), .ctrl_dir_in_o(ctrl_dir_in_o), .irq_o(irq_o));
  task chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    if (!w) rq.push_back(e);
    @(posedge sys_clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (!pready_o && n < 20);
    if (n >= 20) begin
      err_count++;
      report_and_stop();
    end
    {psel_i, penable_i} <= 2'b00;
  endtask
  task tok(input logic [3:0] e, input logic [5:0] f, input logic [1:0] h);
    if (f[4] | f[2]) hq.push_back(h);
    host.send(e, f);
  endtask
  task dir(input logic [3:0] e, input logic exp);
    host.send(e, 6'h00);
    @(negedge sys_clk_i);
    chk(ctrl_dir_in_o, exp, "direction");
  endtask
  // -----------------------------------------
  // result monitor
  // -----------------------------------------
  always @(posedge sys_clk_i) begin
    if (pready_o && !pwrite_i) chk({pslverr_o, prdata_o}, rq.pop_front(), "read");
    if (hs_valid_o) chk(hs_o, hq.pop_front(), "handshake");
  end
  initial begin
    void'($urandom(91));
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    apb(0, OFS_ENDPOINT_STATUS, 0, 33'h0);
    apb(0, 8'h14, 0, {1'b1, 32'h0});
    apb(1, OFS_ENDPOINT_STATUS, 32'h20, 0);
    tok(0, 6'h04, HS_STALL);
    tok(0, 6'h01, 0);
    apb(0, OFS_ENDPOINT_STATUS, 0, 33'h28);
    tok(0, 6'h20, 0);
    tok(0, 6'h04, HS_ACK);
    apb(0, OFS_ENDPOINT_STATUS, 0, 33'h04);
    apb(1, OFS_ENDPOINT_CONTROL, 32'h1, 0);
    apb(1, OFS_ENDPOINT_STATUS, 32'h80, 0);
    dir(0, 1'b1);
    apb(1, OFS_IRQ_MASK, 32'h20, 0);
    for (int k = 0; k < 4; k++) begin
      apb(1, OFS_ENDPOINT_SELECT, 32'h5, 0);
      apb(1, OFS_ENDPOINT_CONTROL, 32'(k), 0);
      apb(1, OFS_ENDPOINT_STATUS, 32'h80, 0);
      dir(5, k == 0);
      tok(5, 6'h02, 0);
      apb(0, OFS_ENDPOINT_STATUS, 0, 33'hC0);
      chk(irq_o, 1'b1, "irq raised");
      tok(5, 6'h18, k == 1 ? HS_NONE : HS_NAK);
      tok(5, 6'h10, k == 1 ? HS_NONE : HS_ACK);
      apb(1, OFS_IRQ_STATUS, 32'h20, 0);
      apb(1, OFS_ENDPOINT_STATUS, 32'h0, 0);
      @(negedge sys_clk_i);
      chk(irq_o, 1'b0, "irq cleared");
    end
    apb(1, OFS_IRQ_MASK, 32'h0, 0);
    tok(5, 6'h02, 0);
    apb(0, OFS_ENDPOINT_STATUS, 0, 33'h40);
    chk(irq_o, 1'b0, "irq masked");
    ep = $urandom % 3 + 1;
    apb(1, OFS_ENDPOINT_SELECT, ep, 0);
    tok(ep[3:0], 6'h02, 0);
    tok(ep[3:0], 6'h18, HS_ACK);
    apb(0, OFS_ENDPOINT_STATUS, 0, 33'h0);
    repeat (4) @(posedge sys_clk_i);
    chk(rq.size() + hq.size(), 0, "pending results");
    report_and_stop();
  end
endmodule
